// File: shared/button_rail_defs.vh
// offsets, field positions, reset values and timing counts of the rail and button controller
`ifndef BUTTON_RAIL_DEFS_VH
`define BUTTON_RAIL_DEFS_VH
// register word addresses
`define OFS_CTRL        3'h0
`define OFS_TIMING      3'h1
`define OFS_MASK        3'h2
`define OFS_FLAGS       3'h3
`define OFS_STATUS      3'h4
// control register fields
`define CTRL_MODE_LSB   0
`define CTRL_TSEL_LSB   2
`define CTRL_WDEN_BIT   5
`define CTRL_RNI_BIT    6
`define CTRL_ACT_LSB    7
`define CTRL_SWRST_BIT  9
`define CTRL_RESET      10'h000
// timing register fields, each a count of 64-tick units
`define TIM_A_LSB       0
`define TIM_B_LSB       8
`define TIM_LONG_LSB    16
`define TIM_WARN_LSB    24
`define TIM_RESET       32'h0c_7d_10_08
`define MASK_RESET      3'h0
// rail supply modes
`define MODE_NORMAL     2'h0
`define MODE_BATTERY    2'h1
`define MODE_FLOAT      2'h2
`define MODE_PULLDOWN   2'h3
// long press actions
`define ACT_POWER_CYCLE 2'h0
`define ACT_NONE        2'h1
// battery tracking target select
`define TSEL_TRACK      3'h0
// timing
`define CLK_PERIOD_NS   25
`define TICK_NS         1000000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define INT_PULSE_NS    128000
`define INT_PULSE_CYC   (`INT_PULSE_NS / `CLK_PERIOD_NS)
`define WATCHDOG_S      14
`define WATCHDOG_TICKS  (`WATCHDOG_S * 1000)
`define RAIL_OFF_TICKS  100
`endif

// File: rtl/press_threshold.v
// one button timer threshold: latches its duration while idle or expired
`timescale 1ns/1ps
module press_threshold (
   input  wire        clk,
   input  wire        rstn,
   input  wire        running,
   input  wire [15:0] elapsed,
   input  wire [15:0] new_limit,
   output wire        reached
);
   reg [15:0] limit_ff;
   wire [15:0] nxt_limit;

   // a new duration waits for expiry or a button restart [RL8]
   assign nxt_limit = (!running || reached) ? new_limit : limit_ff;
   assign reached   = running && (elapsed >= limit_ff) && (limit_ff != 16'h0000);

   // limit register
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         limit_ff <= 16'h0000;
      end else begin
         limit_ff <= nxt_limit;
      end
   end
endmodule

// File: rtl/button_wake_reset_rail_control.v
// rail supply control, push-button timers, power cycle, watchdog and interrupt pulse
//
// What this block does
// RL1: mode 00: input if valid, else battery.
// RL2: mode 01: battery above low level, charging stopped.
// RL3: mode 01 with low battery reverts to 00.
// RL4: mode 10: rail floats, output regulator off.
// RL5: mode 11: rail pulled down, regulator off.
// RL6: modes 10/11 left by write or button reset.
// RL7: select 000 tracks battery times 1.047, floor 3.8V.
// RL8: duration change waits for expiry or restart.
// RL9: first short press sets flag, sends pulse.
// RL10: second short press sets flag, sends pulse.
// RL11: flags held until read; re-interrupt needs clear.
// RL12: ship mode wake needs press through first timer.
// RL13: held button after wake suppresses events until release.
// RL14: valid input during wake attempt exits ship.
// RL15: long press expiry performs selected action.
// RL16: warning flag and pulse before long expiry.
// RL17: change to power cycle during press ignored.
// RL18: option: button reset needs input throughout press.
// RL19: software bit starts power cycle; always-on stays.
// RL20: watchdog resets after 14 s without bus traffic.
// RL21: open-drain 128us pulse only after good start-up.
// RL22: masked events lost; unmasking never pulses.
// RL23: timers count ticks, cleared on button release.
`timescale 1ns/1ps
`include "button_rail_defs.vh"
module button_wake_reset_rail_control #(
   parameter TICK_CYC       = `TICK_CYC,
   parameter INT_PULSE_CYC  = `INT_PULSE_CYC,
   parameter WATCHDOG_TICKS = `WATCHDOG_TICKS,
   parameter RAIL_OFF_TICKS = `RAIL_OFF_TICKS
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire [2:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        button_input_n,
   input  wire        input_supply_valid,
   input  wire        battery_above_low,
   input  wire        startup_done,
   input  wire        startup_fault,
   output wire        rail_from_input,
   output wire        rail_from_battery,
   output wire        rail_pulldown,
   output wire        out_regulator_en,
   output wire        always_on_en,
   output wire        charge_stop,
   output wire        rail_target_track,
   output wire        int_n_out,
   output wire        int_n_oe
);
   localparam [3:0] ST_ON = 4'h1, ST_SHIP = 4'h2, ST_WAKE = 4'h4, ST_CYCLE = 4'h8;

   reg [3:0]  state_ff;
   reg [1:0]  mode_ff;
   reg [2:0]  tsel_ff;
   reg        wd_en_ff;
   reg        rni_ff;
   reg [1:0]  act_ff;
   reg [31:0] timing_ff;
   reg [2:0]  mask_ff;
   reg [2:0]  flag_ff;
   reg [31:0] rdata_ff;
   reg        wait_ff;
   reg [15:0] div_ff;
   reg        tick_ff;
   reg [15:0] press_ff;
   reg [2:0]  hit_ff;
   reg        suppress_ff;
   reg [1:0]  press_act_ff;
   reg        vin_lost_ff;
   reg        long_done_ff;
   reg [15:0] wd_ff;
   reg        wd_done_ff;
   reg [15:0] off_ff;
   reg [15:0] pulse_ff;
   reg        oe_ff;
   reg        out_ff;
   reg        from_in_ff;
   reg        from_bat_ff;
   reg        pull_ff;
   reg        reg_en_ff;
   reg        aon_ff;
   reg        chg_stop_ff;
   reg        track_ff;

   wire       pressed = !button_input_n;
   wire       take    = (avs_read || avs_write) && !wait_ff;
   wire       wr      = avs_write && !wait_ff;
   wire       rd      = avs_read && !wait_ff;
   wire [7:0] tim_a   = timing_ff[`TIM_A_LSB+7:`TIM_A_LSB];
   wire [7:0] tim_b   = timing_ff[`TIM_B_LSB+7:`TIM_B_LSB];
   wire [7:0] tim_l   = timing_ff[`TIM_LONG_LSB+7:`TIM_LONG_LSB];
   wire [7:0] tim_w   = timing_ff[`TIM_WARN_LSB+7:`TIM_WARN_LSB];
   wire [15:0] lim_l  = {2'h0, tim_l, 6'h00};
   wire [15:0] lim_w  = {2'h0, tim_w, 6'h00};
   wire [15:0] lim_warn = (lim_l > lim_w) ? (lim_l - lim_w) : 16'h0001;
   wire [63:0] limits = {lim_l, lim_warn, {2'h0, tim_b, 6'h00}, {2'h0, tim_a, 6'h00}};
   wire [3:0] reached;
   wire       running = pressed && !(state_ff == ST_CYCLE);

   // one threshold per button timer: a, b, warning point, long press
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_thr
         press_threshold u_thr (
            .clk       (clk),
            .rstn      (rstn),
            .running   (running),
            .elapsed   (press_ff),
            .new_limit (limits[gi*16+15:gi*16]),
            .reached   (reached[gi])
         );
      end
   endgenerate

   // new expiries of a, b, warning point and long press
   wire [3:0] expire = reached & ~{long_done_ff, hit_ff};
   wire       on_live = (state_ff == ST_ON) && !suppress_ff;
   // button events are dropped while their flag is still set [RL11]
   wire [2:0] event_v = expire[2:0] & ~flag_ff & {3{on_live}};   // [RL9] [RL10] [RL16]
   wire       start_ok = startup_done && !startup_fault;
   wire       fire = |(event_v & ~mask_ff) && start_ok;             // [RL21] [RL22]

   // long press action; a late switch to power cycle acts as none
   wire [1:0] act_eff = (act_ff == `ACT_POWER_CYCLE && press_act_ff != `ACT_POWER_CYCLE) ?
                        `ACT_NONE : act_ff;                         // [RL17]
   wire       long_fire = expire[3] && on_live;                     // [RL15]
   wire       btn_cycle = long_fire && act_eff == `ACT_POWER_CYCLE &&
                          !(rni_ff && (vin_lost_ff || !input_supply_valid)); // [RL18]
   wire       btn_ship  = long_fire && act_eff[1];
   wire       sw_cycle  = wr && avs_address == `OFS_CTRL && avs_byteenable[1] &&
                          avs_writedata[`CTRL_SWRST_BIT];            // [RL19]
   wire       wd_cycle  = wd_en_ff && !wd_done_ff && input_supply_valid &&
                          wd_ff >= WATCHDOG_TICKS[15:0];             // [RL20]
   wire       any_cycle = (btn_cycle || sw_cycle || wd_cycle) && state_ff == ST_ON;

   // bus slave: request seen with waitrequest high, answered one cycle later
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= !((avs_read || avs_write) && wait_ff);
         if (avs_read && wait_ff) begin
            case (avs_address)
               `OFS_CTRL:   rdata_ff <= {22'h0, 1'b0, act_ff, rni_ff, wd_en_ff, tsel_ff, mode_ff};
               `OFS_TIMING: rdata_ff <= timing_ff;
               `OFS_MASK:   rdata_ff <= {29'h0, mask_ff};
               `OFS_FLAGS:  rdata_ff <= {29'h0, flag_ff};
               `OFS_STATUS: rdata_ff <= {26'h0, suppress_ff, pressed, state_ff};
               default:     rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // writable configuration
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff   <= `MODE_NORMAL;
         tsel_ff   <= `TSEL_TRACK;
         wd_en_ff  <= 1'b0;                                          // [RL20]
         rni_ff    <= 1'b0;
         act_ff    <= `ACT_POWER_CYCLE;
         timing_ff <= `TIM_RESET;
         mask_ff   <= `MASK_RESET;
      end else begin
         if (wr && avs_address == `OFS_CTRL && avs_byteenable[0]) begin
            // battery mode is refused while the battery is low [RL3]
            mode_ff  <= (avs_writedata[1:0] == `MODE_BATTERY && !battery_above_low) ?
                        `MODE_NORMAL : avs_writedata[1:0];           // [RL6]
            tsel_ff  <= avs_writedata[4:2];
            wd_en_ff <= avs_writedata[`CTRL_WDEN_BIT];
            rni_ff   <= avs_writedata[`CTRL_RNI_BIT];
            act_ff[0] <= avs_writedata[`CTRL_ACT_LSB];
         end else if (mode_ff == `MODE_BATTERY && !battery_above_low) begin
            mode_ff <= `MODE_NORMAL;                                 // [RL3]
         end else if (btn_cycle && mode_ff[1]) begin
            mode_ff <= `MODE_NORMAL;                                 // [RL6]
         end
         if (wr && avs_address == `OFS_CTRL && avs_byteenable[1]) begin
            act_ff[1] <= avs_writedata[`CTRL_ACT_LSB+1];
         end
         if (wr && avs_address == `OFS_TIMING) begin
            if (avs_byteenable[0]) timing_ff[7:0]   <= avs_writedata[7:0];
            if (avs_byteenable[1]) timing_ff[15:8]  <= avs_writedata[15:8];
            if (avs_byteenable[2]) timing_ff[23:16] <= avs_writedata[23:16];
            if (avs_byteenable[3]) timing_ff[31:24] <= avs_writedata[31:24];
         end
         if (wr && avs_address == `OFS_MASK && avs_byteenable[0]) begin
            mask_ff <= avs_writedata[2:0];
         end
      end
   end

   // event flags: cleared by reading them, a new event in the same cycle is kept only if its flag was clear
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_ff <= 3'h0;
      end else begin
         flag_ff <= ((rd && avs_address == `OFS_FLAGS) ? 3'h0 : flag_ff) | event_v; // [RL11]
      end
   end

   // low-frequency tick and press duration counter
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_ff   <= 16'h0000;
         tick_ff  <= 1'b0;
         press_ff <= 16'h0000;
         hit_ff   <= 3'h0;
         long_done_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == TICK_CYC[15:0] - 16'h0001);
         div_ff  <= (div_ff == TICK_CYC[15:0] - 16'h0001) ? 16'h0000 : div_ff + 16'h0001;
         if (!running) begin
            press_ff <= 16'h0000;                                    // [RL23]
            hit_ff   <= 3'h0;
            long_done_ff <= 1'b0;
         end else begin
            if (tick_ff && press_ff != 16'hffff) press_ff <= press_ff + 16'h0001; // [RL23]
            hit_ff       <= hit_ff | reached[2:0];
            long_done_ff <= long_done_ff | reached[3];
         end
      end
   end

   // per-press memory: action at press start, input loss, suppression after wake
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         press_act_ff <= `ACT_POWER_CYCLE;
         vin_lost_ff  <= 1'b0;
         suppress_ff  <= 1'b0;
      end else begin
         if (!pressed) begin
            press_act_ff <= act_ff;
            vin_lost_ff  <= 1'b0;
            suppress_ff  <= 1'b0;                                    // [RL13]
         end else begin
            if (!input_supply_valid) vin_lost_ff <= 1'b1;            // [RL18]
            if (state_ff == ST_WAKE || state_ff == ST_SHIP || btn_ship) suppress_ff <= 1'b1; // [RL13]
         end
      end
   end

   // adapter watchdog, cleared by adapter removal, stopped by any bus transfer until the next removal
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wd_ff      <= 16'h0000;
         wd_done_ff <= 1'b0;
      end else begin
         if (!input_supply_valid) begin
            wd_ff      <= 16'h0000;
            wd_done_ff <= 1'b0;
         end else if (take || !wd_en_ff) begin
            wd_ff <= 16'h0000;                                       // [RL20]
            if (take) wd_done_ff <= 1'b1;
         end else if (wd_cycle) begin
            wd_done_ff <= 1'b1;
         end else if (tick_ff) begin
            wd_ff <= wd_ff + 16'h0001;
         end
      end
   end

   // power state machine
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_ON;
         off_ff   <= 16'h0000;
      end else begin
         case (state_ff)
            ST_ON: begin
               off_ff <= 16'h0000;
               if (any_cycle) begin
                  state_ff <= ST_CYCLE;                              // [RL15] [RL19]
               end else if (btn_ship) begin
                  state_ff <= ST_SHIP;                               // [RL15]
               end
            end
            ST_CYCLE: begin
               if (tick_ff) off_ff <= off_ff + 16'h0001;
               if (off_ff >= RAIL_OFF_TICKS[15:0]) state_ff <= ST_ON;
            end
            ST_SHIP: begin
               if (pressed && !suppress_ff) state_ff <= ST_WAKE;     // [RL12]
            end
            ST_WAKE: begin
               if (input_supply_valid || reached[0]) begin
                  state_ff <= ST_ON;                                 // [RL12] [RL14]
               end else if (!pressed) begin
                  state_ff <= ST_SHIP;                               // [RL12]
               end
            end
            default: state_ff <= ST_ON;
         endcase
      end
   end

   // interrupt pulse, open drain: the pin is only ever pulled low
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pulse_ff <= 16'h0000;
         oe_ff    <= 1'b0;
         out_ff   <= 1'b0;
      end else begin
         if (fire) begin
            pulse_ff <= INT_PULSE_CYC[15:0] - 16'h0001;              // [RL21]
            oe_ff    <= 1'b1;
         end else if (pulse_ff != 16'h0000) begin
            pulse_ff <= pulse_ff - 16'h0001;
         end else begin
            oe_ff <= 1'b0;
         end
      end
   end

   // rail switches, regulator and always-on enables
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         from_in_ff  <= 1'b0;
         from_bat_ff <= 1'b0;
         pull_ff     <= 1'b1;
         reg_en_ff   <= 1'b0;
         aon_ff      <= 1'b1;
         chg_stop_ff <= 1'b0;
         track_ff    <= 1'b1;
      end else begin
         track_ff    <= (tsel_ff == `TSEL_TRACK);                   // [RL7]
         aon_ff      <= (state_ff != ST_SHIP);                       // [RL19]
         chg_stop_ff <= (mode_ff == `MODE_BATTERY);                  // [RL2]
         from_in_ff  <= state_ff == ST_ON && mode_ff == `MODE_NORMAL && input_supply_valid;  // [RL1]
         from_bat_ff <= state_ff == ST_ON && (mode_ff == `MODE_NORMAL ? !input_supply_valid :
                        mode_ff == `MODE_BATTERY && battery_above_low);  // [RL2]
         pull_ff     <= state_ff != ST_ON || mode_ff == `MODE_PULLDOWN;  // [RL1] [RL5]
         reg_en_ff   <= state_ff == ST_ON && !mode_ff[1];  // [RL4] [RL5]
      end
   end

   assign avs_readdata      = rdata_ff;
   assign avs_waitrequest   = wait_ff;
   assign rail_from_input   = from_in_ff;
   assign rail_from_battery = from_bat_ff;
   assign rail_pulldown     = pull_ff;
   assign out_regulator_en  = reg_en_ff;
   assign always_on_en      = aon_ff;
   assign charge_stop       = chg_stop_ff;
   assign rail_target_track = track_ff;
   assign int_n_out         = out_ff;
   assign int_n_oe          = oe_ff;
endmodule

// File: tb/button_rail_checker.sv
// concurrent checks on the ports of the rail and button controller
`timescale 1ns/1ps
module button_rail_checker #(
   parameter INT_PULSE_CYC = 8
) (
   input wire clk,
   input wire rstn,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire battery_above_low,
   input wire startup_done,
   input wire startup_fault,
   input wire rail_from_input,
   input wire rail_from_battery,
   input wire rail_pulldown,
   input wire out_regulator_en,
   input wire charge_stop,
   input wire int_n_out,
   input wire int_n_oe
);
   reg [15:0] hi_cnt_ff;
   // length of the running interrupt pulse in cycles
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hi_cnt_ff <= 16'h0000;
      end else if (int_n_oe) begin
         hi_cnt_ff <= hi_cnt_ff + 16'h0001;
      end else begin
         hi_cnt_ff <= 16'h0000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // bus answer one cycle after the request, for one cycle
   chk_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after a request");
   chk_wait_stands_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest stayed low");
   // open-drain pin never drives high and pulses for the set length
   chk_int_drain_only: assert property (int_n_out == 1'b0)
      else $error("interrupt pin drives a high level");
   chk_int_pulse_len: assert property ($fell(int_n_oe) |->
      hi_cnt_ff >= INT_PULSE_CYC && hi_cnt_ff <= INT_PULSE_CYC + 1)
      else $error("interrupt pulse has the wrong length");
   chk_int_needs_start: assert property ($rose(int_n_oe) |->
      $past(startup_done) && !$past(startup_fault))
      else $error("interrupt pulse without a good start-up");
   // rail switches, regulator and charge stop
   chk_source_exclusive: assert property (!(rail_from_input && rail_from_battery))
      else $error("rail fed from both supplies");
   chk_pulldown_isolates: assert property (rail_pulldown |-> !rail_from_input && !rail_from_battery)
      else $error("rail pulled down while connected");
   chk_pulldown_regoff: assert property (rail_pulldown |-> !out_regulator_en)
      else $error("regulator on while rail pulled down");
   chk_low_batt_revert: assert property (!battery_above_low |-> ##[1:3] !charge_stop)
      else $error("battery mode kept with low battery");
endmodule

bind button_wake_reset_rail_control button_rail_checker #(.INT_PULSE_CYC(INT_PULSE_CYC)) checker_i (
   .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .battery_above_low(battery_above_low), .startup_done(startup_done), .startup_fault(startup_fault),
   .rail_from_input(rail_from_input), .rail_from_battery(rail_from_battery), .rail_pulldown(rail_pulldown),
   .out_regulator_en(out_regulator_en), .charge_stop(charge_stop), .int_n_out(int_n_out), .int_n_oe(int_n_oe));

// File: tb/push_button_model.sv
// push button on the far side: held low for a commanded number of cycles
`timescale 1ns/1ps
module push_button_model (
   input  wire        clk,
   input  wire        go,
   input  wire [15:0] hold_cyc,
   output reg         button_input_n
);
   reg [15:0] left_ff;
   initial begin
      button_input_n = 1'b1;
      left_ff = 16'h0000;
   end
   // press on go, release to the pulled-up idle level when the hold runs out
   always @(posedge clk) begin
      if (go) begin
         left_ff <= hold_cyc;
         button_input_n <= 1'b0;
      end else if (left_ff > 16'h0001) begin
         left_ff <= left_ff - 16'h0001;
      end else begin
         left_ff <= 16'h0000;
         button_input_n <= 1'b1;
      end
   end
endmodule

// File: tb/tb.sv
// bench for the rail and button controller: bus tasks, button model and scenarios
`timescale 1ns/1ps
`include "button_rail_defs.vh"
module tb;
   reg         clk, rstn, avs_read, avs_write, go;
   reg  [2:0]  avs_address;
   reg  [31:0] avs_writedata, d;
   reg  [15:0] hold_cyc;
   reg         input_supply_valid, battery_above_low, startup_done, startup_fault;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, button_input_n, rail_from_input, rail_from_battery, rail_pulldown;
   wire        out_regulator_en, always_on_en, charge_stop, rail_target_track, int_n_out, int_n_oe;
   reg         oe_q, watch_off, off_seen, ao_low;
   integer     errors, samples_checked, pulses, i;

   button_wake_reset_rail_control #(.TICK_CYC(4), .INT_PULSE_CYC(8), .WATCHDOG_TICKS(20), .RAIL_OFF_TICKS(3))
   button_wake_reset_rail_control_i (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .button_input_n(button_input_n), .input_supply_valid(input_supply_valid),
      .battery_above_low(battery_above_low), .startup_done(startup_done), .startup_fault(startup_fault),
      .rail_from_input(rail_from_input), .rail_from_battery(rail_from_battery), .rail_pulldown(rail_pulldown),
      .out_regulator_en(out_regulator_en), .always_on_en(always_on_en), .charge_stop(charge_stop),
      .rail_target_track(rail_target_track), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
   push_button_model push_button_model_i (.clk(clk), .go(go), .hold_cyc(hold_cyc), .button_input_n(button_input_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // pulse counter and rail-off watch
   always @(posedge clk) begin
      oe_q <= int_n_oe;
      if (int_n_oe === 1'b1 && oe_q === 1'b0) pulses = pulses + 1;
      if (watch_off && rail_from_input === 1'b0 && rail_from_battery === 1'b0) off_seen = 1'b1;
      if (watch_off && always_on_en !== 1'b1) ao_low = 1'b1;
   end

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task bus(input wr, input [2:0] a, input [31:0] wd);
      integer n;
      begin
         @(posedge clk);
         avs_address <= a;
         avs_writedata <= wd;
         avs_write <= wr;
         avs_read <= !wr;
         n = 0;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n == 20) errors = errors + 1;
         d = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end
   endtask
   task btn(input [15:0] n);
      begin
         @(posedge clk);
         hold_cyc <= n;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
      end
   endtask
   task press(input [15:0] n);
      begin
         btn(n);
         repeat (n + 6) @(posedge clk);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // cuts a hang short
   initial begin
      #1500000;
      errors = errors + 1;
      close_out;
   end

   initial begin
      {rstn, avs_read, avs_write, go, avs_address, avs_writedata, hold_cyc} = 0;
      {input_supply_valid, battery_above_low, startup_done, startup_fault} = 4'b0110;
      {oe_q, watch_off, off_seen, ao_low} = 4'b0000;
      errors = 0;
      samples_checked = 0;
      pulses = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      bus(0, 3'h0, 0); chk(d, `CTRL_RESET);
      bus(0, 3'h1, 0); chk(d, `TIM_RESET);
      bus(0, 3'h2, 0); chk(d, `MASK_RESET);
      bus(0, 3'h5, 0); chk(d, 32'h0);
      for (i = 0; i < 2; i = i + 1) begin
         input_supply_valid <= i[0];
         repeat (4) @(posedge clk);
         chk({rail_from_input, rail_from_battery}, {i[0], !i[0]});
      end
      // every supply mode with the input valid
      for (i = 0; i < 4; i = i + 1) begin
         bus(1, 3'h0, i);
         repeat (4) @(posedge clk);
         chk({rail_from_input, rail_from_battery, rail_pulldown, out_regulator_en, charge_stop},
             {i == 0, i == 1, i == 3, !i[1], i == 1});
      end
      input_supply_valid <= 1'b0;
      press(16'd100); chk(rail_pulldown, 1'b1);
      battery_above_low <= 1'b0;
      bus(1, 3'h0, 32'h1); bus(0, 3'h0, 0); chk(d[1:0], 2'h0);
      battery_above_low <= 1'b1;
      bus(1, 3'h0, 32'h1);
      battery_above_low <= 1'b0;
      repeat (4) @(posedge clk);
      bus(0, 3'h0, 0); chk({d[1:0], charge_stop}, 3'h0);
      battery_above_low <= 1'b1;
      chk(rail_target_track, 1'b1);
      bus(1, 3'h0, 32'h4); repeat (2) @(posedge clk); chk(rail_target_track, 1'b0);
      // action none, timers a=1 b=2 long=4 warn=1 units
      bus(1, 3'h0, 32'h080);
      bus(1, 3'h1, 32'h01040201);
      for (i = 0; i < 2; i = i + 1) begin
         {startup_done, startup_fault} <= {i[0], i[0]};
         pulses = 0;
         press(16'd300); chk(pulses, 0);
         bus(0, 3'h3, 0);
      end
      startup_fault <= 1'b0;
      pulses = 0;
      watch_off = 1'b1;
      off_seen = 1'b0;
      press(16'd1100); chk({pulses, off_seen}, 6);
      press(16'd1100); chk(pulses, 3);
      bus(0, 3'h3, 0); chk(d[2:0], 3'h7);
      bus(0, 3'h3, 0); chk(d[2:0], 3'h0);
      // mask the press events, unmask in mid-press: only warn pulses
      bus(1, 3'h2, 32'h7);
      pulses = 0;
      btn(16'd1100);
      repeat (600) @(posedge clk);
      bus(1, 3'h2, 32'h0);
      repeat (520) @(posedge clk);
      chk(pulses, 1);
      // late switch to power cycle ignored, then an abort of a power cycle
      for (i = 0; i < 2; i = i + 1) begin
         bus(1, 3'h0, i ? 32'h000 : 32'h080);
         off_seen = 1'b0;
         btn(16'd1100);
         repeat (300) @(posedge clk);
         bus(1, 3'h0, i ? 32'h080 : 32'h000);
         repeat (820) @(posedge clk);
         chk(off_seen, 1'b0);
      end
      bus(1, 3'h0, 32'h040); off_seen = 1'b0;
      press(16'd1100); chk(off_seen, 1'b0);
      bus(1, 3'h0, 32'h000); off_seen = 1'b0;
      press(16'd1100); chk({off_seen, ao_low}, 2'b10);
      off_seen = 1'b0;
      bus(1, 3'h0, 32'h200);
      repeat (40) @(posedge clk);
      chk({off_seen, ao_low}, 2'b10);
      bus(0, 3'h0, 0); chk(d[9], 1'b0);
      // adapter watchdog: silent host, then a host that answers
      bus(1, 3'h0, 32'h020);
      for (i = 0; i < 2; i = i + 1) begin
         watch_off = 1'b0;
         input_supply_valid <= 1'b0;
         repeat (4) @(posedge clk);
         input_supply_valid <= 1'b1;
         if (i == 1) bus(0, 3'h4, 0);
         repeat (4) @(posedge clk);
         watch_off = 1'b1;
         off_seen = 1'b0;
         repeat (150) @(posedge clk);
         chk(off_seen, !i[0]);
      end
      // ship mode entry, failed wake, wake with the button still held
      watch_off = 1'b0;
      input_supply_valid <= 1'b0;
      bus(1, 3'h0, 32'h100);
      press(16'd1060); bus(0, 3'h4, 0); chk({d[3:0], always_on_en}, 5'h04);
      press(16'd100); bus(0, 3'h4, 0); chk(d[3:0], 4'h2);
      bus(0, 3'h3, 0);
      pulses = 0;
      btn(16'd600);
      repeat (400) @(posedge clk);
      bus(0, 3'h4, 0); chk(d[5:0], 6'h31);
      repeat (220) @(posedge clk);
      chk(pulses, 0);
      // valid input during a wake attempt leaves ship mode at once
      press(16'd1060);
      btn(16'd600);
      repeat (100) @(posedge clk);
      input_supply_valid <= 1'b1;
      repeat (10) @(posedge clk);
      bus(0, 3'h4, 0); chk(d[3:0], 4'h1);
      repeat (500) @(posedge clk);
      close_out;
   end
endmodule
